//--- hdl/mhp_map.svh
// constants of the parallel host port: register offsets, fields, resets
`ifndef MHP_MAP_SVH
`define MHP_MAP_SVH
`define MHP_OFF_DATA 3'h0
`define MHP_OFF_IEN 3'h1
`define MHP_OFF_IID 3'h2
`define MHP_OFF_LCTL 3'h3
`define MHP_OFF_MCTL 3'h4
`define MHP_OFF_LSTAT 3'h5
`define MHP_OFF_MSTAT 3'h6
`define MHP_OFF_SCR 3'h7
`define MHP_IEN_RDA 0
`define MHP_IEN_THRE 1
`define MHP_IEN_RLS 2
`define MHP_IEN_MS 3
`define MHP_LCTL_DLAB 7
`define MHP_LSTAT_DR 0
`define MHP_LSTAT_OE 1
`define MHP_LSTAT_PE 2
`define MHP_LSTAT_FE 3
`define MHP_LSTAT_BI 4
`define MHP_LSTAT_THRE 5
`define MHP_LSTAT_TEMT 6
`define MHP_RST_ZERO 8'h00
`define MHP_RST_LSTAT 8'h60
`define MHP_IID_NONE 8'h01
`define MHP_IID_RLS 8'h06
`define MHP_IID_RDA 8'h04
`define MHP_IID_THRE 8'h02
`define MHP_IID_MS 8'h00
`endif

//--- hdl/mhp_pkg.sv
// types of the parallel host port
package mhp_pkg;
  typedef enum logic [2:0] {
    MHP_IDLE = 3'b001,
    MHP_READ = 3'b010,
    MHP_WRITE = 3'b100
  } mhp_state_t;
endpackage

//--- hdl/mhp_strobe_edge.sv
// falling and rising edge detector for an active-low host strobe
module mhp_strobe_edge (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic strobe_n,
  output logic start,
  output logic finish
);
  logic strobe_n_r;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      strobe_n_r <= 1'b1;
    else
      strobe_n_r <= strobe_n;
  end

  assign start = strobe_n_r & ~strobe_n;
  assign finish = ~strobe_n_r & strobe_n;
endmodule

//--- hdl/mhp_host_port.sv
// parallel host bus port with a uart-style register set
`include "mhp_map.svh"
module mhp_host_port #(
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic interface_select_strap,
  input wire logic host_chip_select_n,
  input wire logic host_read_n,
  input wire logic host_write_n,
  input wire logic [2:0] host_addr,
  input wire logic [DATA_W-1:0] host_data_in,
  output logic [DATA_W-1:0] host_data_out,
  output logic host_data_oe,
  output logic host_interrupt,
  input wire logic [DATA_W-1:0] mcu_rx_data,
  input wire logic mcu_rx_valid,
  input wire logic [4:1] mcu_rx_errors,
  output logic mcu_rx_taken,
  output logic [DATA_W-1:0] mcu_tx_data,
  output logic mcu_tx_valid,
  input wire logic mcu_tx_done,
  input wire logic [3:0] mcu_modem_in,
  output logic [DATA_W-1:0] mcu_line_ctrl,
  output logic [DATA_W-1:0] mcu_modem_ctrl,
  output logic [15:0] mcu_divisor
);
  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  mhp_pkg::mhp_state_t state_r;
  logic sel;
  logic rd_start;
  logic rd_end;
  logic wr_end;
  logic rd_fire;
  logic wr_fire;
  logic dlab;

  assign sel = interface_select_strap & ~host_chip_select_n;

  mhp_strobe_edge u_rd_edge (
    .clk(clk),
    .sys_rst(sys_rst),
    .strobe_n(host_read_n | ~sel),
    .start(rd_start),
    .finish(rd_end)
  );

  mhp_strobe_edge u_wr_edge (
    .clk(clk),
    .sys_rst(sys_rst),
    .strobe_n(host_write_n | ~sel),
    .start(),
    .finish(wr_end)
  );

  // read side effects land when the strobe ends, write data is taken there
  assign rd_fire = rd_end & (state_r == mhp_pkg::MHP_READ);
  assign wr_fire = wr_end & (state_r == mhp_pkg::MHP_WRITE);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_r <= mhp_pkg::MHP_IDLE;
    else
    begin
      case (state_r)
        mhp_pkg::MHP_IDLE:
          if (sel && !host_read_n)
            state_r <= mhp_pkg::MHP_READ;
          else if (sel && !host_write_n)
            state_r <= mhp_pkg::MHP_WRITE;
        mhp_pkg::MHP_READ:
          if (rd_end)
            state_r <= mhp_pkg::MHP_IDLE;
        mhp_pkg::MHP_WRITE:
          if (wr_end)
            state_r <= mhp_pkg::MHP_IDLE;
        default:
          state_r <= mhp_pkg::MHP_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] ien_r;
  logic [DATA_W-1:0] lctl_r;
  logic [DATA_W-1:0] mctl_r;
  logic [DATA_W-1:0] scr_r;
  logic [DATA_W-1:0] div_lo_r;
  logic [DATA_W-1:0] div_hi_r;
  logic [DATA_W-1:0] rbr_r;
  logic [DATA_W-1:0] thr_r;
  logic [3:0] msr_now_r;
  logic [3:0] msr_delta_r;
  logic dr_r;
  logic thre_r;
  logic tx_busy_r;
  logic [4:1] err_r;
  logic [2:0] addr_r;

  assign dlab = lctl_r[`MHP_LCTL_DLAB];

  // address latched at strobe start, held for the whole access
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      addr_r <= 3'h0;
    else if (state_r == mhp_pkg::MHP_IDLE && sel)
      addr_r <= host_addr;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ien_r <= `MHP_RST_ZERO;
      lctl_r <= `MHP_RST_ZERO;
      mctl_r <= `MHP_RST_ZERO;
      scr_r <= `MHP_RST_ZERO;
      div_lo_r <= `MHP_RST_ZERO;
      div_hi_r <= `MHP_RST_ZERO;
    end
    else if (wr_fire)
    begin
      if (addr_r == `MHP_OFF_DATA && dlab)
        div_lo_r <= host_data_in;
      else if (addr_r == `MHP_OFF_IEN && dlab)
        div_hi_r <= host_data_in;
      else if (addr_r == `MHP_OFF_IEN)
        ien_r <= {4'h0, host_data_in[3:0]};
      else if (addr_r == `MHP_OFF_LCTL)
        lctl_r <= host_data_in;
      else if (addr_r == `MHP_OFF_MCTL)
        mctl_r <= {3'h0, host_data_in[4:0]};
      else if (addr_r == `MHP_OFF_SCR)
        scr_r <= host_data_in;
    end
  end

  // ----------------------------------------------------------------
  // transmit holding register
  // ----------------------------------------------------------------
  logic thr_write;
  assign thr_write = wr_fire && addr_r == `MHP_OFF_DATA && !dlab;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      thr_r <= `MHP_RST_ZERO;
    else if (thr_write)
      thr_r <= host_data_in;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      tx_busy_r <= 1'b0;
    else if (thr_write)
      tx_busy_r <= 1'b1;
    else if (mcu_tx_done)
      tx_busy_r <= 1'b0;
  end

  // tx empty flag: set on handover, cleared by a holding register write
  logic thre_src_rd;
  logic thre_ack_r;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      thre_r <= 1'b1;
    else if (mcu_tx_done)
      thre_r <= 1'b1;
    else if (thr_write)
      thre_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // receive side and line status
  // ----------------------------------------------------------------
  logic rbr_read;
  logic lsr_read;
  logic msr_read;
  logic iid_read;
  assign rbr_read = rd_fire && addr_r == `MHP_OFF_DATA && !dlab;
  assign lsr_read = rd_fire && addr_r == `MHP_OFF_LSTAT;
  assign msr_read = rd_fire && addr_r == `MHP_OFF_MSTAT;
  assign iid_read = rd_fire && addr_r == `MHP_OFF_IID;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rbr_r <= `MHP_RST_ZERO;
    else if (mcu_rx_valid)
      rbr_r <= mcu_rx_data;
  end

  // new data wins over a read in the same cycle
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      dr_r <= 1'b0;
    else if (mcu_rx_valid)
      dr_r <= 1'b1;
    else if (rbr_read)
      dr_r <= 1'b0;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      err_r <= 4'h0;
    else
      err_r <= (lsr_read ? 4'h0 : err_r) |
        (mcu_rx_valid ? mcu_rx_errors : 4'h0);
  end

  // ----------------------------------------------------------------
  // modem status
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      msr_now_r <= 4'h0;
    else
      msr_now_r <= mcu_modem_in;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      msr_delta_r <= 4'h0;
    else
      msr_delta_r <= (msr_read ? 4'h0 : msr_delta_r) |
        (msr_now_r ^ mcu_modem_in);
  end

  // ----------------------------------------------------------------
  // interrupt priority and output
  // ----------------------------------------------------------------
  logic irq_rls;
  logic irq_rda;
  logic irq_thre;
  logic irq_ms;
  logic [DATA_W-1:0] iid;
  assign irq_rls = ien_r[`MHP_IEN_RLS] & (|err_r);
  assign irq_rda = ien_r[`MHP_IEN_RDA] & dr_r;
  assign irq_thre = ien_r[`MHP_IEN_THRE] & thre_r & ~thre_ack_r;
  assign irq_ms = ien_r[`MHP_IEN_MS] & (|msr_delta_r);

  always_comb
  begin
    if (irq_rls)
      iid = `MHP_IID_RLS;
    else if (irq_rda)
      iid = `MHP_IID_RDA;
    else if (irq_thre)
      iid = `MHP_IID_THRE;
    else if (irq_ms)
      iid = `MHP_IID_MS;
    else
      iid = `MHP_IID_NONE;
  end

  // tx empty is serviced by reading its id or writing the holding register
  assign thre_src_rd = iid_read && iid == `MHP_IID_THRE;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      thre_ack_r <= 1'b0;
    else if (mcu_tx_done)
      thre_ack_r <= 1'b0;
    else if (thre_src_rd || thr_write)
      thre_ack_r <= 1'b1;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      host_interrupt <= 1'b0;
    else
      host_interrupt <= interface_select_strap &
        (irq_rls | irq_rda | irq_thre | irq_ms);
  end

  // ----------------------------------------------------------------
  // read data and pin drive
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_mux;
  always_comb
  begin
    if (host_addr == `MHP_OFF_DATA)
      rd_mux = dlab ? div_lo_r : rbr_r;
    else if (host_addr == `MHP_OFF_IEN)
      rd_mux = dlab ? div_hi_r : ien_r;
    else if (host_addr == `MHP_OFF_IID)
      rd_mux = iid;
    else if (host_addr == `MHP_OFF_LCTL)
      rd_mux = lctl_r;
    else if (host_addr == `MHP_OFF_MCTL)
      rd_mux = mctl_r;
    else if (host_addr == `MHP_OFF_LSTAT)
      rd_mux = {1'b0, thre_r & ~tx_busy_r, thre_r, err_r, dr_r};
    else if (host_addr == `MHP_OFF_MSTAT)
      rd_mux = {msr_now_r, msr_delta_r};
    else
      rd_mux = scr_r;
  end

  // data captured when the strobe falls, held steady for the access
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      host_data_out <= `MHP_RST_ZERO;
    else if (rd_start)
      host_data_out <= rd_mux;
  end

  assign host_data_oe = sel & ~host_read_n;

  // ----------------------------------------------------------------
  // mcu side
  // ----------------------------------------------------------------
  assign mcu_rx_taken = rbr_read;
  assign mcu_tx_data = thr_r;
  assign mcu_tx_valid = tx_busy_r;
  assign mcu_line_ctrl = lctl_r;
  assign mcu_modem_ctrl = mctl_r;
  assign mcu_divisor = {div_hi_r, div_lo_r};
endmodule

//--- verif/mhp_host_port_asserts.sv
// concurrent checks on the parallel host port pins
module mhp_host_port_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic interface_select_strap,
  input wire logic host_chip_select_n,
  input wire logic host_read_n,
  input wire logic host_write_n,
  input wire logic [2:0] host_addr,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe,
  input wire logic host_interrupt,
  input wire logic mcu_rx_taken,
  input wire logic mcu_tx_valid,
  input wire logic mcu_tx_done,
  input wire logic [7:0] mcu_line_ctrl
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  pin_drive_a:
    assert property (host_data_oe == (interface_select_strap
      && !host_chip_select_n && !host_read_n)) else $error("oe bad");
  irq_strap_a:
    assert property (!interface_select_strap [*2] |-> !host_interrupt)
    else $error("irq with strap low");
  rdata_hold_a:
    assert property (host_read_n && $past(host_read_n)
      |-> $stable(host_data_out)) else $error("read data moved");
  rx_taken_a:
    assert property (mcu_rx_taken |-> host_addr == 3'h0
      && !host_chip_select_n) else $error("taken without read");
  tx_start_a:
    assert property ($rose(mcu_tx_valid) |-> $past(host_addr) == 3'h0
      && $past(host_write_n) && !$past(host_write_n, 2))
    else $error("tx without write");
  tx_hold_a:
    assert property (mcu_tx_valid && !mcu_tx_done |=> mcu_tx_valid)
    else $error("tx dropped");
  lctl_write_a:
    assert property ($changed(mcu_line_ctrl) |-> $past(host_addr) == 3'h3
      && !$past(host_chip_select_n)) else $error("line ctrl moved");
  irq_rise_a:
    assert property ($rose(host_interrupt) |-> $past(interface_select_strap))
    else $error("irq rose while silent");
  cover property ($rose(host_interrupt));
  cover property ($fell(host_data_oe));
  cover property ($rose(mcu_tx_valid));
endmodule
bind mhp_host_port mhp_host_port_asserts mhp_host_port_asserts_i (.clk,
  .sys_rst, .interface_select_strap, .host_chip_select_n, .host_read_n,
  .host_write_n, .host_addr, .host_data_out, .host_data_oe,
  .host_interrupt, .mcu_rx_taken, .mcu_tx_valid, .mcu_tx_done,
  .mcu_line_ctrl);

//--- verif/mhp_host_model.sv
// host processor model driving the parallel port pins
module mhp_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [2:0] addr,
  output logic [7:0] pin,
  input wire logic [7:0] dout,
  input wire logic oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drv = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [7:0] last = 8'h00;
  // undriven pins keep changing so a stale value never reads right
  assign pin = oe ? dout : drv ? wd : ~last;
  always_ff @(posedge clk) last <= pin;
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 3'h0;
  end
  task acc(input logic w, input logic c, input logic [2:0] a,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    #1;
    addr = a;
    cs_n = !c;
    wd = d;
    drv = w;
    if (w) wr_n = 1'b0;
    else rd_n = 1'b0;
    repeat (3) @(posedge clk);
    q = pin;
    #1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    // chip select outlives the strobe so the end edge is taken
    @(posedge clk);
    #1;
    cs_n = 1'b1;
    drv = 1'b0;
    @(posedge clk);
  endtask
endmodule

//--- verif/tb_top.sv
// self-checking bench of the parallel host port
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b0;
  logic strap = 1'b1;
  logic rx_valid = 1'b0;
  logic tx_done = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic [4:1] rx_err = 4'h0;
  logic [3:0] modem = 4'h0;
  logic cs_n, rd_n, wr_n, oe, irq, taken, tx_valid;
  logic [2:0] addr;
  logic [7:0] pin, dout, q, tx_data;
  int mismatches = 0;
  int total_checks = 0;
  mhp_host_port mhp_host_port_i (.clk, .sys_rst,
    .interface_select_strap(strap), .host_chip_select_n(cs_n),
    .host_read_n(rd_n), .host_write_n(wr_n), .host_addr(addr),
    .host_data_in(pin), .host_data_out(dout), .host_data_oe(oe),
    .host_interrupt(irq), .mcu_rx_data(rx_data), .mcu_rx_valid(rx_valid),
    .mcu_rx_errors(rx_err), .mcu_rx_taken(taken), .mcu_tx_data(tx_data),
    .mcu_tx_valid(tx_valid), .mcu_tx_done(tx_done), .mcu_modem_in(modem),
    .mcu_line_ctrl(), .mcu_modem_ctrl(), .mcu_divisor());
  mhp_host_model mhp_host_model_i (.clk, .cs_n, .rd_n, .wr_n, .addr,
    .pin, .dout, .oe);
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_sim;
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    mhp_host_model_i.acc(1'b1, 1'b1, a, d, q);
  endtask
  task rd(input logic [2:0] a, input logic [7:0] exp);
    mhp_host_model_i.acc(1'b0, 1'b1, a, 8'h00, q);
    chk(q, exp);
  endtask
  task irq_is(input logic exp);
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, irq}, {7'h00, exp});
  endtask
  task rx_byte(input logic [7:0] d, input logic [4:1] e);
    @(posedge clk);
    #1;
    rx_data = d;
    rx_err = e;
    rx_valid = 1'b1;
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    irq_is(1'b0);
    rd(3'h5, 8'h60);
    rd(3'h2, 8'h01);
  endtask
  task t_access;
    wr(3'h7, 8'hA5);
    mhp_host_model_i.acc(1'b1, 1'b0, 3'h7, 8'h5A, q);
    rd(3'h7, 8'hA5);
    #1;
    strap = 1'b0;
    wr(3'h7, 8'h3C);
    #1;
    strap = 1'b1;
    rd(3'h7, 8'hA5);
    wr(3'h3, 8'h03);
    wr(3'h3, 8'h00);
  endtask
  task t_tx;
    wr(3'h1, 8'h02);
    irq_is(1'b1);
    rd(3'h2, 8'h02);
    irq_is(1'b0);
    wr(3'h0, 8'h81);
    chk(tx_data, 8'h81);
    chk({7'h00, tx_valid}, 8'h01);
    @(posedge clk);
    #1;
    tx_done = 1'b1;
    @(posedge clk);
    #1;
    tx_done = 1'b0;
    irq_is(1'b1);
    chk({7'h00, tx_valid}, 8'h00);
    wr(3'h1, 8'h00);
    irq_is(1'b0);
  endtask
  task t_rx;
    wr(3'h1, 8'h05);
    rx_byte(8'h3C, 4'h0);
    irq_is(1'b1);
    rd(3'h2, 8'h04);
    rd(3'h0, 8'h3C);
    irq_is(1'b0);
    rx_byte(8'h11, 4'h2);
    rd(3'h2, 8'h06);
    rd(3'h5, 8'h65);
    rd(3'h0, 8'h11);
    irq_is(1'b0);
  endtask
  task t_modem;
    wr(3'h1, 8'h08);
    #1;
    modem = 4'hF;
    irq_is(1'b1);
    mhp_host_model_i.acc(1'b0, 1'b1, 3'h6, 8'h00, q);
    irq_is(1'b0);
    wr(3'h1, 8'h02);
    irq_is(1'b1);
    sys_rst = 1'b1;
    irq_is(1'b0);
    @(posedge clk);
    #1;
    sys_rst = 1'b0;
    rd(3'h1, 8'h00);
  endtask
  initial
  begin
    // raise reset after time zero so the async branch surely fires
    #1;
    sys_rst = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_reset();
    t_access();
    t_tx();
    t_rx();
    t_modem();
    end_sim();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim();
  end
endmodule
